/* File: hw/acm_monitor.sv */
`timescale 1ns/1ps
module acm_monitor
  import acm_pkg::*;
#(
  parameter int TEMP_CYC = TCONV_CYC,
  parameter int WAIT_STEP = WAIT_STEP_CYC
)(
  input wire logic ref_clk, // System clock
  input wire logic rst_n, // Async reset
  input wire logic sclk, // Serial clock from host
  input wire logic cs_n, // Chip select
  input wire logic sdi, // Serial data in
  output logic sdo, // Serial data out
  output logic sdo_oe, // Serial out drive enable
  input wire logic scan_run, // Autonomous scanning on
  input wire logic [NCH-1:0] chan_en, // Channel enables
  input wire acm_mode_e [N_EXT-1:0] ext_mode, // External input modes
  input wire logic [N_PAIR-1:0] bipolar_en, // Bipolar per differential pair
  input wire logic [NCH-1:0] avg_en, // Averaging per channel
  input wire logic [AVG_W-1:0] avg_log2, // Log2 of averaging depth
  input wire acm_thr_s [NCH-1:0] thr, // Limits per channel
  input wire logic [FLT_W-1:0] fault_limit, // Fault cycles before alarm
  input wire logic [WAIT_W-1:0] scan_wait, // Gap between sequences
  input wire logic [NCH-1:0] alarm_clr, // Clear alarm and fault count
  input wire logic int_push_pull, // Interrupt driver type
  input wire logic int_active_high, // Interrupt polarity
  input wire logic [RES_W-1:0] adc_data, // Converter result
  output acm_mux_s adc_mux, // Converter input selection
  output logic adc_track, // Track/hold acquiring
  output logic adc_convert, // Conversion running
  output logic result_valid, // Result stored pulse
  output logic [CH_W-1:0] result_chan, // Channel of stored result
  output logic [RES_W-1:0] result_data, // Stored result
  output logic [NCH-1:0] alarm, // Alarm register
  output logic int_out, // Interrupt pin level
  output logic int_oe // Interrupt pin drive enable
);
  localparam int TEMP_HALF = TEMP_CYC / 2 - ACQ_CYC;

  if (TEMP_HALF < 2 || WAIT_STEP < 1 || WAIT_STEP * 255 >= 2 ** TMR_W)
  begin : g_bad_param
    $error("acm_monitor: timing parameters out of range");
  end

  typedef enum {S_IDLE, S_ACQ, S_CONV, S_STORE, S_WAIT} acm_state_e;

  // Only the even member leads a pair; an odd input drives the positive side only as a single-ended channel
  function automatic logic ch_diff(input logic [CH_W-1:0] c, input acm_mode_e [N_EXT-1:0] m);
    return !c[3] && !c[0] && (m[c[2:0]] == MODE_DIFF_VOLT || m[c[2:0]] == MODE_DIFF_TEMP);
  endfunction : ch_diff

  function automatic logic ch_temp(input logic [CH_W-1:0] c, input acm_mode_e [N_EXT-1:0] m);
    return c == CH_DIE || (!c[3] && (m[c[2:0]] == MODE_SE_TEMP || m[c[2:0]] == MODE_DIFF_TEMP));
  endfunction : ch_temp

  function automatic logic [CH_W:0] find_ch(input logic [CH_W-1:0] from, input logic [NCH-1:0] m);
    logic [CH_W:0] r;
    r = '0;
    for (int i = NCH - 1; i >= 0; i--)
      if (i >= from && m[i])
        r = {1'b1, CH_W'(i)};
    return r;
  endfunction : find_ch

  // Serial side, link clock domain
  logic spi_rst_n;
  logic [3:0] bit_cnt;
  logic [7:0] cmd_sh;
  logic [7:0] cmd_hold;
  logic cmd_tog;
  logic [TX_W-1:0] tx_sh;
  logic [TX_W-1:0] tx_word;
  logic tx_busy;
  logic [RES_W-1:0] mirror [NCH];

  assign spi_rst_n = rst_n & ~cs_n;

  always_ff @(posedge sclk or negedge spi_rst_n)
    if (!spi_rst_n)
    begin
      bit_cnt <= 4'h0;
      cmd_sh <= 8'h00;
    end
    else if (bit_cnt != CMD_BITS)
    begin
      cmd_sh <= {cmd_sh[6:0], sdi};
      bit_cnt <= bit_cnt + 4'h1;
    end

  // Hold word survives frame end, so the toggle carries a stable word across
  always_ff @(posedge sclk or negedge rst_n)
    if (!rst_n)
    begin
      cmd_tog <= 1'b0;
      cmd_hold <= 8'h00;
    end
    else if (bit_cnt == CMD_BITS - 4'h1)
    begin
      cmd_hold <= {cmd_sh[6:0], sdi};
      cmd_tog <= ~cmd_tog;
    end

  // Mirror is frozen while a frame runs, so it is static when read here
  always_comb
  begin
    tx_word = '0;
    if (cmd_sh[7:4] == OP_RD_DATA && cmd_sh[3:0] < CH_W'(NCH))
      tx_word = {mirror[cmd_sh[3:0]], TX_PAD};
  end

  always_ff @(negedge sclk or negedge spi_rst_n)
    if (!spi_rst_n)
    begin
      tx_busy <= 1'b0;
      sdo <= 1'b0;
      tx_sh <= '0;
    end
    else if (bit_cnt == CMD_BITS && !tx_busy)
    begin
      tx_busy <= 1'b1;
      sdo <= tx_word[TX_W-1];
      tx_sh <= {tx_word[TX_W-2:0], 1'b0};
    end
    else
    begin
      sdo <= tx_sh[TX_W-1];
      tx_sh <= {tx_sh[TX_W-2:0], 1'b0};
    end

  // Crossings into the system clock domain
  logic cs_s1, cs_s2, cs_s3, tg_s1, tg_s2, tg_s3;
  logic cmd_evt, cs_rise;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      tg_s1 <= 1'b0;
      tg_s2 <= 1'b0;
      tg_s3 <= 1'b0;
      sdo_oe <= 1'b0;
    end
    else
    begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      tg_s1 <= cmd_tog;
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
      sdo_oe <= ~cs_s2;
    end

  assign cmd_evt = tg_s2 ^ tg_s3;
  assign cs_rise = cs_s2 & ~cs_s3;

  // Configuration and scan sequencer
  acm_state_e state;
  acm_mode_e [N_EXT-1:0] mode_q;
  logic [N_PAIR-1:0] bip_q;
  logic [NCH-1:0] eff_en;
  logic [CH_W-1:0] ch, man_ch, launch_ch;
  logic is_temp, phase_b, man_run, man_pend, man_arm, launch, man_take, bip_cur;
  logic [TMR_W-1:0] tmr;
  logic [RES_W-1:0] samp_a, raw_reg;
  logic [CH_W:0] first_hit, next_hit;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      mode_q <= {N_EXT{MODE_SE_VOLT}};
      bip_q <= '0;
    end
    else
    begin
      mode_q <= ext_mode;
      bip_q <= bipolar_en;
    end

  // Odd member of a differential pair is covered by its even partner
  for (genvar g = 0; g < NCH; g++)
  begin : g_en
    assign eff_en[g] = chan_en[g] & ~((g % 2 == 1) & ch_diff(CH_W'(g - g % 2), mode_q));
  end

  assign first_hit = find_ch('0, eff_en);
  assign next_hit = find_ch(ch + 4'h1, eff_en);
  assign bip_cur = ch_diff(ch, mode_q) & bip_q[ch[2:1]];

  always_comb
  begin
    launch = 1'b0;
    man_take = 1'b0;
    launch_ch = '0;
    if (state == S_IDLE || state == S_WAIT)
    begin
      if (man_arm)
      begin
        launch = 1'b1;
        man_take = 1'b1;
        launch_ch = man_ch;
      end
      else if (state == S_IDLE && scan_run && first_hit[CH_W])
      begin
        launch = 1'b1;
        launch_ch = first_hit[CH_W-1:0];
      end
    end
    else if (state == S_STORE && !man_run && scan_run && next_hit[CH_W])
    begin
      launch = 1'b1;
      launch_ch = next_hit[CH_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      man_pend <= 1'b0;
      man_arm <= 1'b0;
      man_ch <= '0;
    end
    else if (cmd_evt && cmd_hold[7:4] == OP_CONV && cmd_hold[3:0] < CH_W'(NCH))
    begin
      man_pend <= 1'b1;
      man_ch <= cmd_hold[3:0];
    end
    else if (man_take)
      man_arm <= 1'b0;
    else if (man_pend && cs_rise)
    begin
      man_pend <= 1'b0;
      man_arm <= 1'b1;
    end

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      state <= S_IDLE;
      ch <= '0;
      is_temp <= 1'b0;
      phase_b <= 1'b0;
      man_run <= 1'b0;
      tmr <= '0;
      samp_a <= '0;
      raw_reg <= '0;
      adc_mux <= '0;
      adc_track <= 1'b0;
      adc_convert <= 1'b0;
    end
    else if (launch)
    begin
      state <= S_ACQ;
      ch <= launch_ch;
      is_temp <= ch_temp(launch_ch, mode_q);
      phase_b <= 1'b0;
      man_run <= man_take;
      adc_mux.pos <= launch_ch;
      adc_mux.neg <= ch_diff(launch_ch, mode_q) ? launch_ch + 4'h1 : launch_ch;
      adc_mux.neg_gnd <= ~ch_diff(launch_ch, mode_q);
      adc_mux.bipolar <= ch_diff(launch_ch, mode_q) & bip_q[launch_ch[2:1]];
      adc_mux.bias <= 1'b0;
      adc_track <= 1'b1;
      tmr <= TMR_W'(ACQ_CYC - 1);
    end
    else
      case (state)
        S_ACQ:
          if (tmr == '0)
          begin
            adc_track <= 1'b0;
            adc_convert <= 1'b1;
            tmr <= is_temp ? TMR_W'(TEMP_HALF - 1) : TMR_W'(VCONV_CYC - 1);
            state <= S_CONV;
          end
          else
            tmr <= tmr - 1'b1;
        S_CONV:
          if (tmr != '0)
            tmr <= tmr - 1'b1;
          else if (is_temp && !phase_b)
          begin
            samp_a <= adc_data;
            phase_b <= 1'b1;
            adc_mux.bias <= 1'b1;
            adc_convert <= 1'b0;
            adc_track <= 1'b1;
            tmr <= TMR_W'(ACQ_CYC - 1);
            state <= S_ACQ;
          end
          else
          begin
            adc_convert <= 1'b0;
            if (is_temp)
              raw_reg <= adc_data - samp_a;
            else if (bip_cur)
              raw_reg <= {~adc_data[RES_W-1], adc_data[RES_W-2:0]};
            else
              raw_reg <= adc_data;
            state <= S_STORE;
          end
        S_STORE:
        begin
          man_run <= 1'b0;
          tmr <= TMR_W'(scan_wait) * TMR_W'(WAIT_STEP);
          state <= man_run ? S_IDLE : S_WAIT;
        end
        S_WAIT:
          if (tmr == '0)
            state <= S_IDLE;
          else
            tmr <= tmr - 1'b1;
        default:
          state <= S_IDLE;
      endcase

  // Results, averaging, limits and faults
  logic [RES_W-1:0] data_q [NCH];
  logic signed [ACC_W-1:0] acc [NCH];
  logic [AVG_CNT_W-1:0] avg_cnt [NCH];
  logic [FLT_W-1:0] fcnt [NCH];
  logic signed [ACC_W-1:0] samp, acc_sum, val, up_x, lo_x;
  logic sgn, n_last, do_cmp, viol;
  logic [NCH-1:0] set_vec, clr_vec, spi_clr;

  always_comb
  begin
    sgn = is_temp | bip_cur;
    samp = sgn ? ACC_W'(signed'(raw_reg)) : ACC_W'(raw_reg);
    up_x = sgn ? ACC_W'(signed'(thr[ch].upper)) : ACC_W'(thr[ch].upper);
    lo_x = sgn ? ACC_W'(signed'(thr[ch].lower)) : ACC_W'(thr[ch].lower);
    acc_sum = (avg_cnt[ch] == '0 ? '0 : acc[ch]) + samp;
    n_last = avg_cnt[ch] == AVG_CNT_W'((1 << avg_log2) - 1);
    do_cmp = state == S_STORE && (!avg_en[ch] || n_last);
    val = avg_en[ch] ? acc_sum >>> avg_log2 : samp;
    viol = val > up_x || val < lo_x;
    set_vec = '0;
    if (do_cmp && viol && (fcnt[ch] == '1 || fcnt[ch] + 1'b1 >= fault_limit))
      set_vec[ch] = 1'b1;
    spi_clr = '0;
    if (cmd_evt && cmd_hold[7:4] == OP_CLR_ALL)
      spi_clr = '1;
    else if (cmd_evt && cmd_hold[7:4] == OP_CLR_SEL && cmd_hold[3:0] < CH_W'(NCH))
      spi_clr[cmd_hold[3:0]] = 1'b1;
    clr_vec = alarm_clr | spi_clr;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      for (int i = 0; i < NCH; i++)
      begin
        data_q[i] <= '0;
        mirror[i] <= '0;
        acc[i] <= '0;
        avg_cnt[i] <= '0;
      end
    else
    begin
      if (state == S_STORE)
        data_q[ch] <= raw_reg;
      if (state == S_STORE && avg_en[ch])
      begin
        acc[ch] <= acc_sum;
        avg_cnt[ch] <= n_last ? '0 : avg_cnt[ch] + 1'b1;
      end
      if (cs_s2)
        mirror <= data_q;
    end

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      for (int i = 0; i < NCH; i++)
        fcnt[i] <= '0;
    else
      for (int i = 0; i < NCH; i++)
        if (clr_vec[i])
          fcnt[i] <= '0;
        else if (do_cmp && ch == CH_W'(i))
          fcnt[i] <= !viol ? '0 : (fcnt[i] == '1 ? fcnt[i] : fcnt[i] + 1'b1);

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      alarm <= '0;
      result_valid <= 1'b0;
      result_chan <= '0;
      result_data <= '0;
    end
    else
    begin
      alarm <= (alarm & ~clr_vec) | set_vec;
      result_valid <= state == S_STORE;
      result_chan <= ch;
      result_data <= raw_reg;
    end

  // Open drain can only pull low, so it drives only the low level
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      int_out <= 1'b0;
      int_oe <= 1'b0;
    end
    else if (int_push_pull)
    begin
      int_oe <= 1'b1;
      int_out <= (|alarm) ~^ int_active_high;
    end
    else
    begin
      int_oe <= ~((|alarm) ~^ int_active_high);
      int_out <= 1'b0;
    end

  // Checks
  logic [TMR_W-1:0] trk_cnt, cnv_cnt;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      trk_cnt <= '0;
      cnv_cnt <= '0;
    end
    else
    begin
      trk_cnt <= adc_track ? trk_cnt + 1'b1 : '0;
      cnv_cnt <= adc_convert ? cnv_cnt + 1'b1 : '0;
    end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_final_end;
    $fell(adc_convert) && !adc_track;
  endsequence

  sequence s_new_alarm;
    (alarm & ~$past(alarm)) != '0;
  endsequence

  a_acq_time: assert property ($fell(adc_track) |-> trk_cnt == TMR_W'(ACQ_CYC))
    else $error("acquisition length wrong");
  a_conv_time: assert property ($fell(adc_convert) |->
      cnv_cnt == (is_temp ? TMR_W'(TEMP_HALF) : TMR_W'(VCONV_CYC)))
    else $error("conversion length wrong");
  a_result_out: assert property (s_final_end |=> result_valid && result_chan == $past(ch))
    else $error("result not stored after conversion");
  a_only_enabled: assert property ($rose(adc_track) && !man_run |-> eff_en[ch])
    else $error("disabled channel converted");
  a_se_ground: assert property (adc_track && !adc_mux.pos[3] &&
      mode_q[adc_mux.pos[2:0]] inside {MODE_SE_VOLT, MODE_SE_TEMP}
      |-> adc_mux.neg_gnd && !adc_mux.bipolar)
    else $error("single-ended input not grounded");
  a_diff_pair: assert property (adc_track && !adc_mux.neg_gnd |->
      !adc_mux.pos[0] && adc_mux.neg == adc_mux.pos + 4'h1)
    else $error("bad differential pair");
  a_alarm_cause: assert property (s_new_alarm |-> $past(do_cmp && viol))
    else $error("alarm without violation");
  a_int_follows: assert property (int_push_pull && $rose(|alarm) |=>
      int_out == $past(int_active_high))
    else $error("interrupt not asserted");
  a_od_no_high: assert property ($past(!int_push_pull) |-> !(int_oe && int_out))
    else $error("open drain drives high");
  a_sdo_release: assert property (cs_s2 |=> !sdo_oe)
    else $error("serial output driven while deselected");
endmodule : acm_monitor

/* File: hw/acm_pkg.sv */
package acm_pkg;
  localparam int NCH = 10;
  localparam int N_EXT = 8;
  localparam int N_PAIR = 4;
  localparam int RES_W = 12;
  localparam int CH_W = 4;
  localparam logic [3:0] CH_DIE = 4'h9;
  localparam int CLK_MHZ = 100;
  localparam int VCONV_NS = 10600;
  localparam int TCONV_NS = 46000;
  localparam int ACQ_NS = 1500;
  localparam int VCONV_CYC = (VCONV_NS * CLK_MHZ + 999) / 1000;
  localparam int TCONV_CYC = (TCONV_NS * CLK_MHZ + 999) / 1000;
  localparam int ACQ_CYC = (ACQ_NS * CLK_MHZ + 999) / 1000;
  localparam int WAIT_STEP_CYC = 100;
  localparam int TMR_W = 24;
  localparam int WAIT_W = 8;
  localparam int FLT_W = 4;
  localparam int AVG_W = 2;
  localparam int AVG_CNT_W = 3;
  localparam int ACC_W = 15;
  localparam int TX_W = 16;
  localparam logic [3:0] CMD_BITS = 4'h8;
  localparam logic [3:0] OP_CONV = 4'h0;
  localparam logic [3:0] OP_RD_DATA = 4'h2;
  localparam logic [3:0] OP_CLR_SEL = 4'h8;
  localparam logic [3:0] OP_CLR_ALL = 4'h9;
  localparam logic [3:0] TX_PAD = 4'h0;

  typedef enum logic [1:0] {
    MODE_SE_VOLT,
    MODE_DIFF_VOLT,
    MODE_SE_TEMP,
    MODE_DIFF_TEMP
  } acm_mode_e;

  typedef struct packed {
    logic [RES_W-1:0] upper;
    logic [RES_W-1:0] lower;
  } acm_thr_s;

  typedef struct packed {
    logic [CH_W-1:0] pos;
    logic [CH_W-1:0] neg;
    logic neg_gnd;
    logic bipolar;
    logic bias;
  } acm_mux_s;
endpackage : acm_pkg

/* File: verification/acm_host_model.sv */
`timescale 1ns/1ps
module acm_host_model #(
  parameter int HALF_NS = 80
)(
  output logic sclk, // Serial clock to device
  output logic cs_n, // Chip select, active low
  output logic sdi, // Serial data to device
  input wire logic sdo // Serial data from device
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  // Clock stands still between frames; offset keeps phase unrelated to ref_clk
  task automatic xfer(input logic [7:0] cmd, output logic [15:0] rd);
    rd = 16'h0000;
    #(HALF_NS / 3);
    cs_n = 1'b0;
    #(HALF_NS);
    for (int i = 0; i < 24; i++)
    begin
      sdi = (i < 8) ? cmd[7-i] : 1'b0;
      #(HALF_NS);
      sclk = 1'b1;
      if (i >= 8)
        rd = {rd[14:0], sdo};
      #(HALF_NS);
      sclk = 1'b0;
    end
    #(HALF_NS);
    cs_n = 1'b1;
    // Released line must not keep showing the last bit
    sdi = ~sdi;
    #(HALF_NS);
  endtask : xfer
endmodule : acm_host_model

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import acm_pkg::*;
;
  logic ref_clk, rst_n, sclk, cs_n, sdi, sdo, sdo_oe, scan_run;
  logic [NCH-1:0] chan_en, avg_en, alarm_clr, alarm;
  acm_mode_e [N_EXT-1:0] ext_mode;
  logic [N_PAIR-1:0] bipolar_en;
  logic [AVG_W-1:0] avg_log2;
  acm_thr_s [NCH-1:0] thr;
  logic [FLT_W-1:0] fault_limit;
  logic [WAIT_W-1:0] scan_wait;
  logic int_push_pull, int_active_high, adc_track, adc_convert, result_valid;
  logic int_out, int_oe;
  logic [RES_W-1:0] adc_data, result_data;
  logic [CH_W-1:0] result_chan;
  acm_mux_s adc_mux;
  int n_errors = 0;
  int checked = 0;

  acm_monitor #(.TEMP_CYC(400), .WAIT_STEP(2)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .scan_run(scan_run), .chan_en(chan_en), .ext_mode(ext_mode),
    .bipolar_en(bipolar_en), .avg_en(avg_en), .avg_log2(avg_log2), .thr(thr),
    .fault_limit(fault_limit), .scan_wait(scan_wait), .alarm_clr(alarm_clr),
    .int_push_pull(int_push_pull), .int_active_high(int_active_high),
    .adc_data(adc_data), .adc_mux(adc_mux), .adc_track(adc_track),
    .adc_convert(adc_convert), .result_valid(result_valid), .result_chan(result_chan),
    .result_data(result_data), .alarm(alarm), .int_out(int_out), .int_oe(int_oe)
  );

  acm_host_model u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t %s: got %0h expected %0h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic print_verdict;
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  always @(sdo)
    if (cs_n === 1'b0 && sclk === 1'b1)
      chk(1'b0, 1'b1, "serial out moved on rising clock");

  // Sel: 0 track, 1 convert, 2 result strobe
  task automatic wt(input int sel, input logic lvl, input int lim);
    logic s;
    for (int i = 0; i < lim; i++)
    begin
      @(posedge ref_clk);
      #1;
      s = (sel == 0) ? adc_track : (sel == 1) ? adc_convert : result_valid;
      if (s === lvl)
        return;
    end
    chk(1'b0, 1'b1, "wait expired");
  endtask : wt

  task automatic cnt(input int sel, output int n);
    logic s;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      n++;
      s = (sel == 0) ? adc_track : adc_convert;
    end
    while (s === 1'b1 && n < 5000);
  endtask : cnt

  // Stops scanning and lets any running step finish
  task automatic idle;
    @(posedge ref_clk);
    scan_run <= 1'b0;
    repeat (3000) @(posedge ref_clk);
  endtask : idle

  task automatic t_volt;
    int n;
    @(posedge ref_clk);
    chan_en <= 10'h001;
    adc_data <= 12'h5A3;
    scan_run <= 1'b1;
    wt(0, 1'b1, 20);
    chk({adc_mux.pos, adc_mux.neg_gnd, adc_mux.bipolar}, {4'h0, 2'b10}, "se mux");
    cnt(0, n);
    chk(n, ACQ_CYC, "track length");
    cnt(1, n);
    chk(n, VCONV_CYC, "convert length");
    wt(2, 1'b1, 4);
    chk({result_chan, result_data}, {4'h0, 12'h5A3}, "se result");
    wt(2, 1'b1, 3000);
    chk(result_chan, 4'h0, "rescan");
    idle();
  endtask : t_volt

  task automatic t_spi;
    logic [15:0] rd;
    chk(sdo_oe, 1'b0, "out enabled while deselected");
    fork
      u_host.xfer(8'h20, rd);
      begin
        #1000;
        chk(sdo_oe, 1'b1, "out not driven in frame");
      end
    join
    chk(rd, {12'h5A3, 4'h0}, "read data");
    repeat (5) @(posedge ref_clk);
    chk(sdo_oe, 1'b0, "out not released");
    u_host.xfer(8'h2C, rd);
    chk(rd, 16'h0000, "read of absent channel");
    u_host.xfer(8'h01, rd);
    wt(0, 1'b1, 20);
    chk(adc_mux.pos, 4'h1, "manual channel");
    wt(2, 1'b1, 1400);
    chk({result_chan, result_data}, {4'h1, 12'h5A3}, "manual result");
  endtask : t_spi

  task automatic t_diff;
    @(posedge ref_clk);
    ext_mode[2] <= MODE_DIFF_VOLT;
    bipolar_en <= 4'b0010;
    chan_en <= 10'h00C;
    adc_data <= 12'h123;
    @(posedge ref_clk);
    scan_run <= 1'b1;
    wt(0, 1'b1, 20);
    chk({adc_mux.pos, adc_mux.neg, adc_mux.neg_gnd, adc_mux.bipolar},
        {4'h2, 4'h3, 2'b01}, "diff mux");
    wt(2, 1'b1, 1300);
    chk({result_chan, result_data}, {4'h2, 12'h923}, "bipolar result");
    wt(2, 1'b1, 1400);
    chk(result_chan, 4'h2, "odd channel not skipped");
    idle();
  endtask : t_diff

  task automatic t_inner;
    @(posedge ref_clk);
    ext_mode[2] <= MODE_SE_VOLT;
    chan_en <= 10'h300;
    adc_data <= 12'h400;
    scan_run <= 1'b1;
    wt(2, 1'b1, 1400);
    chk({result_chan, result_data}, {4'h8, 12'h400}, "supply result");
    wt(0, 1'b1, 20);
    chk({adc_mux.pos, adc_mux.bias}, {CH_DIE, 1'b0}, "die first phase");
    wt(1, 1'b1, 300);
    wt(0, 1'b1, 2000);
    chk(adc_mux.bias, 1'b1, "bias phase");
    @(posedge ref_clk);
    adc_data <= 12'h4A0;
    wt(2, 1'b1, 2000);
    chk({result_chan, result_data}, {CH_DIE, 12'h0A0}, "temperature difference");
    idle();
  endtask : t_inner

  task automatic t_alarm;
    logic [15:0] rd;
    u_host.xfer(8'h90, rd);
    repeat (10) @(posedge ref_clk);
    chk(alarm, 10'h000, "clear all");
    chan_en <= 10'h001;
    adc_data <= 12'h900;
    thr[0] <= {12'h800, 12'h100};
    fault_limit <= 4'h2;
    scan_run <= 1'b1;
    wt(2, 1'b1, 1400);
    repeat (3) @(posedge ref_clk);
    chk(alarm, 10'h000, "alarm too early");
    wt(2, 1'b1, 1400);
    repeat (3) @(posedge ref_clk);
    chk({alarm, int_out, int_oe}, {10'h001, 2'b11}, "alarm and pin");
    idle();
    int_active_high <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(int_out, 1'b0, "active low level");
    int_push_pull <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({int_out, int_oe}, 2'b01, "open drain active");
    u_host.xfer(8'h80, rd);
    repeat (10) @(posedge ref_clk);
    chk({alarm, int_oe}, {10'h000, 1'b0}, "clear selected");
    int_push_pull <= 1'b1;
    int_active_high <= 1'b1;
  endtask : t_alarm

  task automatic t_avg;
    @(posedge ref_clk);
    avg_en <= 10'h001;
    avg_log2 <= 2'h1;
    adc_data <= 12'hF00;
    fault_limit <= 4'h1;
    scan_run <= 1'b1;
    wt(2, 1'b1, 1400);
    repeat (3) @(posedge ref_clk);
    chk(alarm, 10'h000, "single sample compared");
    // Second sample alone is in range, so only the mean can trip the limit
    adc_data <= 12'h500;
    wt(2, 1'b1, 1400);
    repeat (3) @(posedge ref_clk);
    chk(alarm, 10'h001, "average compared");
    idle();
    alarm_clr <= 10'h001;
    @(posedge ref_clk);
    alarm_clr <= 10'h000;
    repeat (3) @(posedge ref_clk);
    chk(alarm, 10'h000, "clear by port");
  endtask : t_avg

  initial
  begin
    rst_n = 1'b0;
    scan_run = 1'b0;
    chan_en = 10'h000;
    ext_mode = {N_EXT{MODE_SE_VOLT}};
    bipolar_en = 4'h0;
    avg_en = 10'h000;
    avg_log2 = 2'h0;
    for (int i = 0; i < NCH; i++)
      thr[i] = {12'hFFF, 12'h000};
    fault_limit = 4'h1;
    scan_wait = 8'h00;
    alarm_clr = 10'h000;
    int_push_pull = 1'b1;
    int_active_high = 1'b1;
    adc_data = 12'h000;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk({sdo_oe, alarm, adc_track}, 12'h000, "after reset");
    t_volt();
    t_spi();
    t_diff();
    t_inner();
    t_alarm();
    t_avg();
    print_verdict();
  end

  initial
  begin
    #900000;
    n_errors++;
    print_verdict();
  end
endmodule : tb_top
